// ### power_on_reset_watchdog.sv
// Power-on reset generator with supply monitor and pulse-programmed watchdog.
// Assumes supply_sense_in is a comparator level, high while the supply is in range.
`timescale 1ns/1ps

// How it works
// R1: Host reset output stays low from power-up until the power-on delay ends.
// R2: A 128 us delay starts once the supply sense reports good supply.
// R3: When the delay expires the host reset output is released high.
// R4: Supply fault drives reset low 128 us, release only after supply recovers.
// R5: Watchdog period lies anywhere between 1 ms and 10 s.
// R6: Host must refresh at least once per period or a reset follows.
// R7: First refresh pulse longer than 1 ms, shorter than 10 s, sets period.
// R8: Without programming the period is 10 s and expiry resets the host.
// R9: Every watchdog reset reloads the 10 s default period.
// R10: Inhibit high disables the watchdog; no watchdog reset ever issues.
// R11: Host should refresh from its main loop, not a free timer.
// R12: Watchdog expiry holds reset low for 128 us, then releases it.
module power_on_reset_watchdog #(
    parameter int POR_TICKS        = supervisor_pkg::POR_DELAY_TICKS,
    parameter int WD_MIN_TICKS     = supervisor_pkg::WD_MIN_TICKS,
    parameter int WD_MAX_TICKS     = supervisor_pkg::WD_MAX_TICKS,
    parameter int WD_DEFAULT_TICKS = supervisor_pkg::WD_DEFAULT_TICKS,
    parameter int WD_W             = supervisor_pkg::WD_CNT_W
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Supervised pins
    input  wire logic supply_sense_in,
    input  wire logic watchdog_refresh_pulse,
    input  wire logic watchdog_inhibit,
    // Host reset
    output logic      host_reset_out_n
);

    // ********************************
    // Pin synchronisation
    // ********************************
    logic [2:0] sync_lvl;

    pin_sync #(.WIDTH(3)) u_pin_sync (
        .clk       (mclk),
        .reset_n   (reset_n),
        .pin_in    ({supply_sense_in, watchdog_refresh_pulse, watchdog_inhibit}),
        .level_out (sync_lvl)
    );

    wire supply_ok   = sync_lvl[2];
    wire refresh_lvl = sync_lvl[1];
    wire inhibit_lvl = sync_lvl[0];

    logic refresh_d_reg;
    wire  refresh_rise = refresh_lvl & ~refresh_d_reg;
    wire  refresh_fall = ~refresh_lvl & refresh_d_reg;

    // ********************************
    // Microsecond tick
    // ********************************
    logic [supervisor_pkg::TICK_W-1:0] div_reg;
    wire tick = div_reg == supervisor_pkg::TICK_W'(supervisor_pkg::TICK_CYCLES - 1);
    wire [supervisor_pkg::TICK_W-1:0] div_next =
        tick ? '0 : div_reg + supervisor_pkg::TICK_W'(1);

    // ********************************
    // Supervisor sequencing
    // ********************************
    supervisor_pkg::supervisor_state_e state_reg;
    supervisor_pkg::supervisor_state_e state_next;
    logic [supervisor_pkg::HOLD_CNT_W-1:0] hold_cnt_reg;
    logic [WD_W-1:0] wd_cnt_reg;
    logic [WD_W-1:0] pw_cnt_reg;
    logic [WD_W-1:0] period_reg;
    logic            programmed_reg;

    wire in_run   = state_reg == supervisor_pkg::ST_RUN;
    wire hold_run = state_reg == supervisor_pkg::ST_DELAY || state_reg == supervisor_pkg::ST_HOLD;
    wire hold_done = tick && hold_cnt_reg == supervisor_pkg::HOLD_CNT_W'(POR_TICKS - 1);

    // ********************************
    // Watchdog decode
    // ********************************
    wire wd_run    = in_run && !inhibit_lvl;                               // [R10]
    wire wd_expire = wd_run && wd_cnt_reg >= period_reg;                  // [R8]
    wire pw_in_range = pw_cnt_reg > WD_W'(WD_MIN_TICKS)
                    && pw_cnt_reg < WD_W'(WD_MAX_TICKS);                   // [R5] [R7]
    // Expiry wins over a pulse ending in the same cycle, so the reload is kept
    wire prog_take = in_run && refresh_fall && !programmed_reg && pw_in_range
                  && !wd_expire;                                          // [R7] [R9]

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            supervisor_pkg::ST_WAIT: begin
                if (supply_ok) begin
                    state_next = supervisor_pkg::ST_DELAY;                // [R2]
                end
            end
            supervisor_pkg::ST_DELAY: begin
                if (!supply_ok) begin
                    state_next = supervisor_pkg::ST_WAIT;
                end else if (hold_done) begin
                    state_next = supervisor_pkg::ST_RUN;                  // [R3]
                end
            end
            supervisor_pkg::ST_RUN: begin
                if (!supply_ok || wd_expire) begin
                    state_next = supervisor_pkg::ST_HOLD;                 // [R4] [R12]
                end
            end
            supervisor_pkg::ST_HOLD: begin
                if (hold_done) begin
                    // Release only when the supply is back in range
                    state_next = supply_ok ? supervisor_pkg::ST_RUN
                                           : supervisor_pkg::ST_WAIT;     // [R4]
                end
            end
        endcase
    end

    wire [supervisor_pkg::HOLD_CNT_W-1:0] hold_cnt_next =
        (state_next != state_reg || !hold_run) ? '0 :
        tick ? hold_cnt_reg + supervisor_pkg::HOLD_CNT_W'(1) : hold_cnt_reg;

    // Refresh edge restarts the window; programming pulse end does too
    wire [WD_W-1:0] wd_cnt_next =
        (!wd_run || refresh_rise || prog_take) ? '0 :
        tick ? wd_cnt_reg + WD_W'(1) : wd_cnt_reg;

    // Width saturates at the maximum so an overlong pulse is never accepted
    wire [WD_W-1:0] pw_cnt_next =
        !refresh_lvl ? '0 :
        (tick && pw_cnt_reg != WD_W'(WD_MAX_TICKS)) ? pw_cnt_reg + WD_W'(1) : pw_cnt_reg;

    // Any reset entry reloads the default period
    wire [WD_W-1:0] period_next =
        (wd_expire || !in_run) ? WD_W'(WD_DEFAULT_TICKS) :               // [R9]
        prog_take ? pw_cnt_reg : period_reg;                              // [R7]

    wire programmed_next = (wd_expire || !in_run) ? 1'b0 :
                           prog_take ? 1'b1 : programmed_reg;

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg        <= supervisor_pkg::ST_WAIT;
            host_reset_out_n <= 1'b0;                                     // [R1]
            div_reg          <= '0;
            hold_cnt_reg     <= '0;
            refresh_d_reg    <= 1'b0;
        end else begin
            state_reg        <= state_next;
            host_reset_out_n <= state_next == supervisor_pkg::ST_RUN;    // [R1] [R3]
            div_reg          <= div_next;
            hold_cnt_reg     <= hold_cnt_next;
            refresh_d_reg    <= refresh_lvl;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wd_cnt_reg     <= '0;
            pw_cnt_reg     <= '0;
            period_reg     <= WD_W'(WD_DEFAULT_TICKS);                    // [R8]
            programmed_reg <= 1'b0;
        end else begin
            wd_cnt_reg     <= wd_cnt_next;
            pw_cnt_reg     <= pw_cnt_next;
            period_reg     <= period_next;
            programmed_reg <= programmed_next;
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_reset_until_run: assert property ( // [R1]
        !in_run |-> !host_reset_out_n)
        else $error("host reset released outside run state");

    chk_delay_start: assert property ( // [R2]
        state_reg == supervisor_pkg::ST_WAIT && supply_ok
        |=> state_reg == supervisor_pkg::ST_DELAY && hold_cnt_reg == '0)
        else $error("power-on delay did not start on good supply");

    chk_delay_release: assert property ( // [R3]
        state_reg == supervisor_pkg::ST_DELAY && supply_ok && hold_done
        |=> host_reset_out_n && in_run)
        else $error("reset not released at end of power-on delay");

    chk_fault_assert: assert property ( // [R4]
        in_run && !supply_ok |=> !host_reset_out_n
        && state_reg == supervisor_pkg::ST_HOLD && hold_cnt_reg == '0)
        else $error("supply fault did not assert reset");

    chk_fault_wait_clear: assert property ( // [R4]
        state_reg == supervisor_pkg::ST_HOLD && hold_done && !supply_ok
        |=> state_reg == supervisor_pkg::ST_WAIT && !host_reset_out_n)
        else $error("reset released while supply still bad");

    chk_hold_length: assert property ( // [R12]
        hold_run && tick |-> hold_cnt_reg < supervisor_pkg::HOLD_CNT_W'(POR_TICKS))
        else $error("reset hold counter overran its length");

    chk_period_range: assert property ( // [R5]
        period_reg > WD_W'(WD_MIN_TICKS) && period_reg <= WD_W'(WD_DEFAULT_TICKS))
        else $error("watchdog period out of range");

    chk_prog_adopt: assert property ( // [R7]
        prog_take |=> period_reg == $past(pw_cnt_reg) && programmed_reg)
        else $error("programming pulse width not adopted");

    chk_default_period: assert property ( // [R8]
        !programmed_reg |-> period_reg == WD_W'(WD_DEFAULT_TICKS))
        else $error("unprogrammed watchdog period not default");

    chk_expire_reload: assert property ( // [R9]
        wd_expire |=> period_reg == WD_W'(WD_DEFAULT_TICKS)
        && !host_reset_out_n ##1 !host_reset_out_n)
        else $error("watchdog reset did not reload default");

    chk_inhibit_quiet: assert property ( // [R10]
        inhibit_lvl |-> !wd_expire && wd_cnt_next == '0)
        else $error("watchdog active while inhibited");

    chk_hold_release: assert property ( // [R12]
        state_reg == supervisor_pkg::ST_HOLD && hold_done && supply_ok
        |=> host_reset_out_n)
        else $error("reset not released after hold");

    cov_power_up: cover property (
        state_reg == supervisor_pkg::ST_DELAY ##1 in_run);
    cov_supply_fault: cover property (
        in_run && !supply_ok);
    cov_programmed: cover property (
        prog_take);
    cov_wd_expire: cover property (
        wd_expire);

endmodule

// ### supervisor_pkg.sv
// Shared constants and state encoding for the reset supervisor.
// Assumes a 100 MHz mclk; all supervisor timing runs on a 1 us tick.
package supervisor_pkg;

    // ********************************
    // Time base
    // ********************************
    localparam int CLK_HZ      = 100_000_000;
    localparam int TICK_HZ     = 1_000_000;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int TICK_W      = 7;

    // ********************************
    // Reset timing
    // ********************************
    localparam int POR_DELAY_US    = 128;
    localparam int POR_DELAY_TICKS = POR_DELAY_US * (TICK_HZ / 1_000_000);
    localparam int HOLD_CNT_W      = 16;

    // ********************************
    // Watchdog timing
    // ********************************
    localparam int WD_MIN_MS        = 1;
    localparam int WD_MAX_S         = 10;
    localparam int WD_DEFAULT_S     = 10;
    localparam int WD_MIN_TICKS     = WD_MIN_MS * (TICK_HZ / 1000);
    localparam int WD_MAX_TICKS     = WD_MAX_S * TICK_HZ;
    localparam int WD_DEFAULT_TICKS = WD_DEFAULT_S * TICK_HZ;
    localparam int WD_CNT_W         = 24;

    // ********************************
    // Supervisor states
    // ********************************
    typedef enum logic [1:0] {
        ST_WAIT  = 2'h0,
        ST_DELAY = 2'h1,
        ST_RUN   = 2'h2,
        ST_HOLD  = 2'h3
    } supervisor_state_e;

endpackage

// ### pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels; output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Pins and filtered levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg   <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            meta_reg   <= pin_in;
            stage2_reg <= meta_reg;
            stage3_reg <= stage2_reg;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            wire agree = stage2_reg[i] == stage3_reg[i];
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    level_out[i] <= 1'b0;
                end else if (agree) begin
                    level_out[i] <= stage3_reg[i];
                end
            end
        end
    endgenerate

endmodule

// ### host_model.sv
// Behavioural host processor: watches the reset line, programs and refreshes the watchdog.
// Assumes the bench sets prog_ticks, read at reset release, and gap_cycles, read per refresh.
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic        mclk,
    // Reset from the supervisor
    input  wire logic        host_reset_out_n,
    // Behaviour controls from the bench
    input  wire logic [31:0] prog_ticks,
    input  wire logic [31:0] gap_cycles,
    // Refresh pin
    output logic             watchdog_refresh_pulse
);
    // ********************************
    // Main loop
    // ********************************
    initial watchdog_refresh_pulse = 1'b0;

    // Pulses come from the software loop, so a stalled loop stops them
    always begin
        @(posedge mclk);
        if (host_reset_out_n === 1'b1) begin
            // One long pulse sets the period, width chosen by the bench
            if (prog_ticks > 0) begin
                watchdog_refresh_pulse <= 1'b1;
                repeat (prog_ticks * supervisor_pkg::TICK_CYCLES) @(posedge mclk);
                watchdog_refresh_pulse <= 1'b0;
            end
            // Short refresh within every window; gap of zero means a hung host
            while (host_reset_out_n === 1'b1) begin
                if (gap_cycles == 0) begin
                    @(posedge mclk);
                end else begin
                    repeat (gap_cycles) @(posedge mclk);
                    watchdog_refresh_pulse <= 1'b1;
                    repeat (50) @(posedge mclk);
                    watchdog_refresh_pulse <= 1'b0;
                end
            end
        end
    end
endmodule

// ### tb_power_on_reset_watchdog.sv
// Self-checking bench for the reset supervisor with shortened counts.
// Assumes a 1 us tick of 100 mclk cycles; windows allow for sync and tick phase.
`timescale 1ns/1ps
module tb_power_on_reset_watchdog;
    localparam int T   = supervisor_pkg::TICK_CYCLES;
    localparam int POR = 4;
    localparam int WDD = 100;

    logic mclk;
    logic reset_n;
    logic supply_sense_in;
    logic watchdog_inhibit;
    logic watchdog_refresh_pulse;
    logic host_reset_out_n;
    int   prog_ticks;
    int   gap_cycles;
    int   n_mismatch;
    int   checked;
    int   cnt;

    power_on_reset_watchdog #(.POR_TICKS(POR), .WD_MIN_TICKS(10), .WD_MAX_TICKS(WDD),
        .WD_DEFAULT_TICKS(WDD), .WD_W(supervisor_pkg::WD_CNT_W)) i_dut (
        .mclk                   (mclk),
        .reset_n                (reset_n),
        .supply_sense_in        (supply_sense_in),
        .watchdog_refresh_pulse (watchdog_refresh_pulse),
        .watchdog_inhibit       (watchdog_inhibit),
        .host_reset_out_n       (host_reset_out_n)
    );

    host_model i_host (
        .mclk                   (mclk),
        .host_reset_out_n       (host_reset_out_n),
        .prog_ticks             (prog_ticks),
        .gap_cycles             (gap_cycles),
        .watchdog_refresh_pulse (watchdog_refresh_pulse)
    );

    // ********************************
    // Shared tasks
    // ********************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Count cycles until reset shows val; gives up at max and returns max
    task automatic wait_level(input logic val, input int max, output int n);
        n = 0;
        while (host_reset_out_n !== val && n < max) begin
            @(posedge mclk);
            n++;
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic power_up();
        repeat (20) @(posedge mclk);
        check("held_before_supply", host_reset_out_n, 1'b0);
        supply_sense_in <= 1'b1;
        repeat ((POR - 1) * T - 10) @(posedge mclk);
        check("held_during_delay", host_reset_out_n, 1'b0);
        wait_level(1'b1, 2 * T, cnt);
        check("released_after_delay", cnt < 2 * T, 1'b1);
    endtask

    task automatic supply_faults();
        supply_sense_in <= 1'b0;
        repeat (50) @(posedge mclk);
        supply_sense_in <= 1'b1;
        wait_level(1'b1, 8 * T, cnt);
        check("short_fault_hold", cnt >= 250 && cnt <= 560, 1'b1);
        supply_sense_in <= 1'b0;
        repeat (10 * T) @(posedge mclk);
        check("held_while_fault", host_reset_out_n, 1'b0);
        supply_sense_in <= 1'b1;
        wait_level(1'b1, 8 * T, cnt);
        check("delay_after_fault", cnt >= 300 && cnt <= 520, 1'b1);
    endtask

    task automatic default_timeout();
        wait_level(1'b0, 12000, cnt);
        check("default_period", cnt >= 9800 && cnt <= 10300, 1'b1);
        prog_ticks <= 30;
        gap_cycles <= 2000;
        wait_level(1'b1, 8 * T, cnt);
        check("wd_hold", cnt >= 300 && cnt <= 560, 1'b1);
    endtask

    task automatic programmed_period();
        repeat (10) @(posedge mclk);
        prog_ticks <= 0;
        wait_level(1'b0, 20000, cnt);
        check("refreshed_no_reset", cnt, 32'h0000_4E20);
        gap_cycles <= 0;
        wait_level(1'b0, 8000, cnt);
        check("programmed_period", cnt >= 900 && cnt <= 5500, 1'b1);
        prog_ticks <= 5;
        wait_level(1'b1, 8 * T, cnt);
        repeat (10) @(posedge mclk);
        prog_ticks <= 0;
        wait_level(1'b0, 12000, cnt);
        check("default_reloaded", cnt >= 9800 && cnt <= 10900, 1'b1);
    endtask

    task automatic inhibited();
        watchdog_inhibit <= 1'b1;
        wait_level(1'b1, 8 * T, cnt);
        wait_level(1'b0, 12000, cnt);
        check("inhibit_no_reset", cnt, 32'h0000_2EE0);
        watchdog_inhibit <= 1'b0;
        wait_level(1'b0, 10500, cnt);
        check("uninhibit_resets", cnt < 10500, 1'b1);
    endtask

    // ********************************
    // Main sequence and watchdog
    // ********************************
    initial begin
        n_mismatch = 0;
        checked = 0;
        prog_ticks = 0;
        gap_cycles = 0;
        reset_n = 1'b0;
        supply_sense_in = 1'b0;
        watchdog_inhibit = 1'b0;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        power_up();
        supply_faults();
        default_timeout();
        programmed_period();
        inhibited();
        tally_and_finish();
    end

    // Runs about 70k cycles; cut off at 95k
    initial begin
        #950_000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
